// file: hdl/io_ctrl_map.svh
// Offsets, field positions, reset values and carrier codes of the I/O control block
// Behaviour
// - Decode op: working register nibble through decoder into selected latch slot
// - Blanking decode: zero nibble yields all-zero latch pattern
// - Pair load: register nibble on lines A-D, result nibble on E-H
// - Table load: table ROM word bits 0-7 straight onto lines A-H
// - Indexed decode, blank and pair forms take the nibble at the index pointer
// - Port C setup: bit 4 picks pull-low or low-level hold, bits 3-0 direction
// - Port C pull-low applies only to pins set as inputs
// - Port write ops drive the memory nibble onto the port output latch
// - Port read ops sample pins into result nibble and memory location
// - Special port A write: pins 1-2 from nibble, pin 3 immediate, pin 4 pulse
// - With wake enable, bit 6 picks key-press or every-cycle wake, then status
// - Mode 000 drives one column chosen by bits 3-0
// - Mode 001 drives all sixteen columns, bits 3-0 ignored
// - Mode 010 disables scanning, bits 3-0 ignored
// - Mode 10x drives eight columns chosen by bit 3
// - Mode 110 drives four columns chosen by bits 3-2
// - Mode 111 drives two adjacent columns chosen by bits 3-1
// - Scan setting from result and memory nibbles, or from the table ROM word
// - Buzzer: bits 8-6 pick carrier, bits 5-0 enable envelope taps
// - Converter control: bits 0-2 oscillator enables, bit 3 counter enable
// - Working register index maps to data memory address plus 70H
`ifndef IO_CTRL_MAP_SVH
`define IO_CTRL_MAP_SVH
`define WREG_BASE 9'h070
`define SETUP_PULL_BIT 4
`define SCAN_WAKE_BIT 6
`define SCAN_RESET 8'h20
`define BUZZ_RESET 9'h000
`define CONV_RESET 6'h00
`define TAP_4K 3
`define TAP_2K 4
`define TAP_1K 5
`define TAP_ENV_LO 10
`define CAR_GEN 3'h7
`define CAR_HIGH 3'h4
`define CAR_4K 3'h3
`define CAR_2K 3'h2
`define CAR_1K 3'h1
`define PORT_A 2'h0
`define PORT_C 2'h2
`endif

// file: hdl/io_ctrl_pkg.sv
// Types shared by the I/O control block and its core-side users
package io_ctrl_pkg;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_DEC_R = 5'h01, OP_BLANK_R = 5'h02, OP_PAIR_R = 5'h03, OP_TAB = 5'h04,
    OP_DEC_HL = 5'h05, OP_BLANK_HL = 5'h06, OP_PAIR_HL = 5'h07,
    OP_SETUP_A = 5'h08, OP_SETUP_B = 5'h09, OP_SETUP_C = 5'h0A, OP_SETUP_D = 5'h0B,
    OP_WRITE_A = 5'h0C, OP_WRITE_B = 5'h0D, OP_WRITE_C = 5'h0E, OP_WRITE_D = 5'h0F,
    OP_READ_A = 5'h10, OP_READ_B = 5'h11, OP_READ_C = 5'h12, OP_READ_D = 5'h13,
    OP_WRITE_A_SPECIAL = 5'h14, OP_SCAN_IMM = 5'h15, OP_SCAN_REG = 5'h16,
    OP_SCAN_TAB = 5'h17, OP_BUZZ = 5'h18, OP_CONV = 5'h19
  } io_op_e;
  // One operation as the core presents it, with its operands already fetched
  typedef struct packed {
    io_op_e op;
    logic [4:0] latch_slot_index;
    logic [2:0] work_reg_index;
    logic [8:0] index_pointer;
    logic [8:0] imm;
    logic [3:0] mem_nibble;
    logic [3:0] main_result_nibble;
    logic [7:0] table_word;
  } io_req_s;
  typedef logic [3:0][3:0] port_bus_t;
endpackage

// file: hdl/io_instruction_peripheral_control.sv
// Port, latch-load, key-scan, buzzer and converter control for the I/O operations
`timescale 1ns/10ps
`default_nettype none
`include "io_ctrl_map.svh"
module io_instruction_peripheral_control (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire io_ctrl_pkg::io_req_s req_i,
  input wire io_ctrl_pkg::port_bus_t pin_i,
  input wire logic key_pressed_i,
  input wire logic scan_cycle_done_i,
  input wire logic keyscan_wake_enable_i,
  input wire logic wake_clr_i,
  input wire logic status_clr_i,
  input wire logic [15:0] prescaler_taps_i,
  input wire logic tone_generator_output_i,
  output logic latch_we_o,
  output logic [4:0] latch_addr_o,
  output logic [7:0] latch_data_o,
  output logic ac_we_o,
  output logic [3:0] ac_data_o,
  output logic mem_we_o,
  output logic [8:0] mem_addr_o,
  output logic [3:0] mem_data_o,
  output io_ctrl_pkg::port_bus_t port_out_o,
  output io_ctrl_pkg::port_bus_t port_oe_o,
  output io_ctrl_pkg::port_bus_t pull_low_o,
  output logic [3:0] port_c_hold_o,
  output logic [15:0] scan_columns_o,
  output logic keyscan_wake_request_o,
  output logic keyscan_status_flag_o,
  output logic tone_out_o,
  output logic tone_out_inverted_o,
  output logic [2:0] osc_enable_o,
  output logic counter_enable_o,
  output logic timer2_gate_o,
  output logic capacitor_gate_pin_o
);
  import io_ctrl_pkg::*;

  // Digit pattern decoder, segments a..g on bits 0..6
  function automatic logic [7:0] seg_decode(input logic [3:0] nib, input logic blank);
    logic [7:0] pat;
    pat = 8'h00;
    case (nib)
      4'h0: pat = 8'h3F; 4'h1: pat = 8'h06; 4'h2: pat = 8'h5B; 4'h3: pat = 8'h4F;
      4'h4: pat = 8'h66; 4'h5: pat = 8'h6D; 4'h6: pat = 8'h7D; 4'h7: pat = 8'h07;
      4'h8: pat = 8'h7F; 4'h9: pat = 8'h6F; 4'hA: pat = 8'h77; 4'hB: pat = 8'h7C;
      4'hC: pat = 8'h39; 4'hD: pat = 8'h5E; 4'hE: pat = 8'h79; default: pat = 8'h71;
    endcase
    if (blank && nib == 4'h0) begin
      pat = 8'h00;
    end
    return pat;
  endfunction

  // Column mask for a scan setting; used by the column drive logic
  function automatic logic [15:0] scan_mask(input logic [7:0] s);
    logic [15:0] m;
    m = 16'h0000;
    if (s[7] && !s[5]) begin
      m = s[3] ? 16'hFF00 : 16'h00FF;
    end else if (s[7] && s[5] && !s[4]) begin
      m = 16'h000F << {s[3:2], 2'b00};
    end else if (s[7] && s[5] && s[4]) begin
      m = 16'h0003 << {s[3:1], 1'b0};
    end else if (!s[5] && !s[4]) begin
      m = 16'h0001 << s[3:0];
    end else if (!s[5] && s[4]) begin
      m = 16'hFFFF;
    end else begin
      m = 16'h0000;
    end
    return m;
  endfunction

  // Two-stage synchronisers for all port pins and the key sense line
  port_bus_t pin_meta_ff, pin_sync_ff;
  logic key_meta_ff, key_sync_ff;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      key_meta_ff <= 1'b0;
      key_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= pin_i;
      pin_sync_ff <= pin_meta_ff;
      key_meta_ff <= key_pressed_i;
      key_sync_ff <= key_meta_ff;
    end
  end

  // Operation effects: latch, write-back, port setup and output, settings
  logic latch_we_ff, nxt_latch_we;
  logic [4:0] latch_addr_ff, nxt_latch_addr;
  logic [7:0] latch_data_ff, nxt_latch_data;
  logic ac_we_ff, nxt_ac_we, mem_we_ff, nxt_mem_we;
  logic [3:0] ac_data_ff, nxt_ac_data, mem_data_ff, nxt_mem_data;
  logic [8:0] mem_addr_ff, nxt_mem_addr;
  port_bus_t out_ff, nxt_out, dir_ff, nxt_dir, pull_pin_ff, nxt_pull_pin;
  logic [3:0] pull_en_ff, nxt_pull_en, hold_ff, nxt_hold;
  logic pulse_ff, nxt_pulse;
  logic [7:0] scan_set_ff, nxt_scan_set;
  logic [8:0] buzz_ff, nxt_buzz;
  logic [5:0] conv_ff, nxt_conv;
  logic [1:0] port_sel;
  logic [8:0] wreg_addr;

  always_comb begin
    nxt_latch_we = 1'b0;
    nxt_latch_addr = latch_addr_ff;
    nxt_latch_data = latch_data_ff;
    nxt_ac_we = 1'b0;
    nxt_ac_data = ac_data_ff;
    nxt_mem_we = 1'b0;
    nxt_mem_addr = mem_addr_ff;
    nxt_mem_data = mem_data_ff;
    nxt_out = out_ff;
    nxt_dir = dir_ff;
    nxt_pull_en = pull_en_ff;
    nxt_pulse = 1'b0;
    nxt_scan_set = scan_set_ff;
    nxt_buzz = buzz_ff;
    nxt_conv = conv_ff;
    port_sel = req_i.op[1:0];
    wreg_addr = `WREG_BASE + {6'h00, req_i.work_reg_index};
    // The pin 4 pulse lasts one cycle; a new write may restart it
    if (pulse_ff) begin
      nxt_out[`PORT_A][3] = 1'b0;
    end
    if (req_valid_i) begin
      case (req_i.op)
        OP_DEC_R, OP_DEC_HL, OP_BLANK_R, OP_BLANK_HL: begin
          nxt_latch_we = 1'b1;
          nxt_latch_addr = req_i.latch_slot_index;
          nxt_latch_data = seg_decode(req_i.mem_nibble, req_i.op[1]);
        end
        OP_PAIR_R, OP_PAIR_HL: begin
          nxt_latch_we = 1'b1;
          nxt_latch_addr = req_i.latch_slot_index;
          nxt_latch_data = {req_i.main_result_nibble, req_i.mem_nibble};
        end
        OP_TAB: begin
          nxt_latch_we = 1'b1;
          nxt_latch_addr = req_i.latch_slot_index;
          nxt_latch_data = req_i.table_word;
        end
        OP_SETUP_A, OP_SETUP_B, OP_SETUP_C, OP_SETUP_D: begin
          nxt_pull_en[port_sel] = req_i.imm[`SETUP_PULL_BIT];
          nxt_dir[port_sel] = req_i.imm[3:0];
        end
        OP_WRITE_A, OP_WRITE_B, OP_WRITE_C, OP_WRITE_D: begin
          nxt_out[port_sel] = req_i.mem_nibble;
        end
        OP_READ_A, OP_READ_B, OP_READ_C, OP_READ_D: begin
          nxt_ac_we = 1'b1;
          nxt_ac_data = pin_sync_ff[port_sel];
          nxt_mem_we = 1'b1;
          nxt_mem_addr = wreg_addr;
          nxt_mem_data = pin_sync_ff[port_sel];
        end
        OP_WRITE_A_SPECIAL: begin
          nxt_out[`PORT_A] = {1'b1, req_i.imm[0], req_i.mem_nibble[1:0]};
          nxt_pulse = 1'b1;
        end
        OP_SCAN_IMM: nxt_scan_set = req_i.imm[7:0];
        OP_SCAN_REG: nxt_scan_set = {req_i.main_result_nibble, req_i.mem_nibble};
        OP_SCAN_TAB: nxt_scan_set = req_i.table_word;
        OP_BUZZ: nxt_buzz = req_i.imm;
        OP_CONV: nxt_conv = req_i.imm[5:0];
        default: nxt_latch_we = 1'b0;
      endcase
    end
    // Per-pin pull enables are registered so the pins see no decode glitches
    for (int p = 0; p < 4; p++) begin
      nxt_pull_pin[p] = nxt_pull_en[p] ? 4'hF : 4'h0;
    end
    nxt_pull_pin[`PORT_C] = nxt_pull_en[`PORT_C] ? ~nxt_dir[`PORT_C] : 4'h0;
    nxt_hold = nxt_pull_en[`PORT_C] ? 4'h0 : ~nxt_dir[`PORT_C];
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_we_ff <= 1'b0;
      latch_addr_ff <= 5'h00;
      latch_data_ff <= 8'h00;
      ac_we_ff <= 1'b0;
      ac_data_ff <= 4'h0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= 9'h000;
      mem_data_ff <= 4'h0;
      out_ff <= '0;
      dir_ff <= '0;
      pull_en_ff <= 4'h0;
      pull_pin_ff <= '0;
      hold_ff <= 4'hF;
      pulse_ff <= 1'b0;
      scan_set_ff <= `SCAN_RESET;
      buzz_ff <= `BUZZ_RESET;
      conv_ff <= `CONV_RESET;
    end else begin
      latch_we_ff <= nxt_latch_we;
      latch_addr_ff <= nxt_latch_addr;
      latch_data_ff <= nxt_latch_data;
      ac_we_ff <= nxt_ac_we;
      ac_data_ff <= nxt_ac_data;
      mem_we_ff <= nxt_mem_we;
      mem_addr_ff <= nxt_mem_addr;
      mem_data_ff <= nxt_mem_data;
      out_ff <= nxt_out;
      dir_ff <= nxt_dir;
      pull_en_ff <= nxt_pull_en;
      pull_pin_ff <= nxt_pull_pin;
      hold_ff <= nxt_hold;
      pulse_ff <= nxt_pulse;
      scan_set_ff <= nxt_scan_set;
      buzz_ff <= nxt_buzz;
      conv_ff <= nxt_conv;
    end
  end

  // Key scan: column drive, wake request, then status one cycle later
  logic [15:0] cols_ff, nxt_cols;
  logic wake_ff, nxt_wake, status_ff, nxt_status, pend_ff, nxt_pend;
  logic scan_on, wake_hit;
  always_comb begin
    scan_on = !(!scan_set_ff[7] && scan_set_ff[5:4] == 2'h2); // Mode 010 switches scanning off
    wake_hit = scan_cycle_done_i && scan_on && keyscan_wake_enable_i &&
               (scan_set_ff[`SCAN_WAKE_BIT] || key_sync_ff);
    nxt_cols = scan_mask(scan_set_ff);
    nxt_pend = wake_hit;
    // Set beats clear so an event in the clearing cycle is kept
    nxt_wake = wake_hit || (wake_ff && !wake_clr_i);
    nxt_status = pend_ff || (status_ff && !status_clr_i);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cols_ff <= 16'h0000;
      wake_ff <= 1'b0;
      status_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      cols_ff <= nxt_cols;
      wake_ff <= nxt_wake;
      status_ff <= nxt_status;
      pend_ff <= nxt_pend;
    end
  end

  // Buzzer carrier and envelope; taps come from the same-clock prescaler
  logic tone_ff, nxt_tone, tone_n_ff, nxt_tone_n, carrier, env;
  always_comb begin
    case (buzz_ff[8:6])
      `CAR_GEN: carrier = tone_generator_output_i;
      `CAR_HIGH: carrier = 1'b1;
      `CAR_4K: carrier = prescaler_taps_i[`TAP_4K];
      `CAR_2K: carrier = prescaler_taps_i[`TAP_2K];
      `CAR_1K: carrier = prescaler_taps_i[`TAP_1K];
      default: carrier = 1'b0;
    endcase
    env = (buzz_ff[5:0] == 6'h00) || |(buzz_ff[5:0] & prescaler_taps_i[`TAP_ENV_LO +: 6]);
    nxt_tone = carrier && env;
    nxt_tone_n = !(carrier && env); // Own flop keeps both tone pins on one edge
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tone_ff <= 1'b0;
      tone_n_ff <= 1'b1;
    end else begin
      tone_ff <= nxt_tone;
      tone_n_ff <= nxt_tone_n;
    end
  end

  assign latch_we_o = latch_we_ff;
  assign latch_addr_o = latch_addr_ff;
  assign latch_data_o = latch_data_ff;
  assign ac_we_o = ac_we_ff;
  assign ac_data_o = ac_data_ff;
  assign mem_we_o = mem_we_ff;
  assign mem_addr_o = mem_addr_ff;
  assign mem_data_o = mem_data_ff;
  assign port_out_o = out_ff;
  assign port_oe_o = dir_ff;
  assign pull_low_o = pull_pin_ff;
  assign port_c_hold_o = hold_ff;
  assign scan_columns_o = cols_ff;
  assign keyscan_wake_request_o = wake_ff;
  assign keyscan_status_flag_o = status_ff;
  assign tone_out_o = tone_ff;
  assign tone_out_inverted_o = tone_n_ff;
  // Gate bits are stored as written; software keeps them consistent
  assign osc_enable_o = conv_ff[2:0];
  assign counter_enable_o = conv_ff[3];
  assign timer2_gate_o = conv_ff[4];
  assign capacitor_gate_pin_o = conv_ff[5];

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence wake_seq;
    scan_cycle_done_i && keyscan_wake_enable_i && scan_on && scan_set_ff[6];
  endsequence
  sequence flags_seq;
    keyscan_wake_request_o ##1 keyscan_status_flag_o;
  endsequence
  chk_wake_then_status: assert property (wake_seq |=> flags_seq)
    else $error("wake or status flag missing after scan cycle");
  chk_blank_zero: assert property (req_valid_i && req_i.op == OP_BLANK_HL && req_i.mem_nibble == 4'h0
    |=> latch_we_o && latch_data_o == 8'h00)
    else $error("blank decode of zero not all zeros");
  chk_pair_lines: assert property (req_valid_i && req_i.op == OP_PAIR_R
    |=> latch_data_o == {$past(req_i.main_result_nibble), $past(req_i.mem_nibble)})
    else $error("pair load lines wrong");
  chk_read_wb_addr: assert property (req_valid_i && req_i.op == OP_READ_B
    |=> mem_we_o && ac_we_o && mem_addr_o == 9'h070 + $past(req_i.work_reg_index))
    else $error("port read write-back wrong");
  chk_pulse_width: assert property (req_valid_i && req_i.op == OP_WRITE_A_SPECIAL
    ##1 !(req_valid_i && req_i.op == OP_WRITE_A_SPECIAL) |-> port_out_o[0][3] ##1 !port_out_o[0][3])
    else $error("pin 4 pulse not one cycle");
  chk_portc_pull: assert property (pull_low_o[2] == (pull_low_o[2] & ~port_oe_o[2]))
    else $error("port C pull-low on output pin");
  chk_scan_single: assert property (!scan_set_ff[7] && scan_set_ff[5:4] == 2'h0
    |=> scan_columns_o == 16'h0001 << $past(scan_set_ff[3:0]))
    else $error("single scan column wrong");
  chk_scan_off: assert property (scan_set_ff[7:4] == 4'b0010 |=> scan_columns_o == 16'h0000)
    else $error("scan not disabled");
  chk_tone_quiet: assert property (buzz_ff[8:6] inside {3'h5, 3'h6} |=> !tone_out_o && tone_out_inverted_o)
    else $error("undefined carrier not quiet");
  chk_conv_bits: assert property (req_valid_i && req_i.op == OP_CONV
    |=> counter_enable_o == $past(req_i.imm[3]) && osc_enable_o == $past(req_i.imm[2:0]))
    else $error("converter control not applied");
endmodule // io_instruction_peripheral_control
`default_nettype wire

// file: test/core_issue_model.sv
// Core-side issue model that presents operations and keeps converter gating legal
`timescale 1ns/10ps
`default_nettype none
module core_issue_model (
  input wire logic go_i,
  input wire io_ctrl_pkg::io_req_s cmd_i,
  output logic req_valid_o,
  output io_ctrl_pkg::io_req_s req_o
);
  import io_ctrl_pkg::*;
  // Software never sets both gates, and always enables the counter with a gate
  always_comb begin
    req_valid_o = go_i;
    req_o = cmd_i;
    if (cmd_i.op == OP_CONV) begin
      if (cmd_i.imm[5]) req_o.imm[4] = 1'b0;
      if (cmd_i.imm[5] | cmd_i.imm[4]) req_o.imm[3] = 1'b1;
    end
  end
endmodule // core_issue_model
`default_nettype wire

// file: test/io_instruction_peripheral_control_tb_top.sv
// Self-checking bench for the I/O operation control block
`timescale 1ns/10ps
`default_nettype none
module io_instruction_peripheral_control_tb_top;
  import io_ctrl_pkg::*;
  localparam logic [7:0] SEG [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07,
    8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
  logic clk, rstn, go, valid, key, done, wen, wclr, sclr, gen;
  io_req_s cmd, req;
  port_bus_t pins, pout, poe, pull;
  logic [15:0] taps, cols;
  logic lwe, awe, mwe, wake, stat, tone, tone_n, cen, t2g, cxg;
  logic [4:0] laddr;
  logic [7:0] ldata;
  logic [3:0] adata, mdata, hold, nib;
  logic [8:0] maddr, x;
  logic [2:0] osc;
  int n_mismatch, n_compared, p;

  core_issue_model core (.go_i(go), .cmd_i(cmd), .req_valid_o(valid), .req_o(req));
  io_instruction_peripheral_control dut (.core_clk_i(clk), .resetn_i(rstn), .req_valid_i(valid), .req_i(req),
    .pin_i(pins), .key_pressed_i(key), .scan_cycle_done_i(done), .keyscan_wake_enable_i(wen), .wake_clr_i(wclr),
    .status_clr_i(sclr), .prescaler_taps_i(taps), .tone_generator_output_i(gen), .latch_we_o(lwe),
    .latch_addr_o(laddr), .latch_data_o(ldata), .ac_we_o(awe), .ac_data_o(adata), .mem_we_o(mwe),
    .mem_addr_o(maddr), .mem_data_o(mdata), .port_out_o(pout), .port_oe_o(poe), .pull_low_o(pull),
    .port_c_hold_o(hold), .scan_columns_o(cols), .keyscan_wake_request_o(wake), .keyscan_status_flag_o(stat),
    .tone_out_o(tone), .tone_out_inverted_o(tone_n), .osc_enable_o(osc), .counter_enable_o(cen),
    .timer2_gate_o(t2g), .capacitor_gate_pin_o(cxg));

  // Column pattern a scan setting should produce
  function automatic logic [15:0] scan_exp(input logic [7:0] s);
    case ({s[7], s[5], s[4]})
      3'b000: return 16'h0001 << s[3:0];
      3'b001: return 16'hFFFF;
      3'b010: return 16'h0000;
      3'b011: return 16'h0000; // Undefined mode drives no column
      3'b110: return 16'h000F << {s[3:2], 2'b00};
      3'b111: return 16'h0003 << {s[3:1], 1'b0};
      default: return s[3] ? 16'hFF00 : 16'h00FF;
    endcase
  endfunction

  // Tone level from carrier code and envelope taps; undefined codes stay quiet
  function automatic logic tone_exp(input logic [8:0] b);
    logic c;
    case (b[8:6])
      3'h7: c = gen;
      3'h4: c = 1'b1;
      3'h3: c = taps[3];
      3'h2: c = taps[4];
      3'h1: c = taps[5];
      default: c = 1'b0;
    endcase
    return c & ((b[5:0] == 6'h00) | (|(b[5:0] & taps[15:10])));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One request pulse; effects are checked just after the taking edge
  task automatic op(input io_op_e o, input logic [8:0] imm, input logic [3:0] mem, ac);
    @(posedge clk);
    go <= 1'b1;
    cmd <= '{op: o, latch_slot_index: 5'($urandom), work_reg_index: 3'($urandom), index_pointer: 9'h000,
      imm: imm, mem_nibble: mem, main_result_nibble: ac, table_word: imm[7:0]};
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask

  task automatic lchk(input logic [7:0] d);
    chk({lwe, laddr, ldata}, {1'b1, cmd.latch_slot_index, d});
  endtask

  // Scan end pulse, then wake at +1 and status at +2, then both cleared
  task automatic scan_done(input logic exp);
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    #1;
    chk(wake, exp);
    @(posedge clk);
    #1;
    chk(stat, exp);
    wclr <= 1'b1;
    sclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
    sclr <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Whole run is under a thousand cycles; this limit only catches a hang
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {rstn, go, key, done, wen, wclr, sclr, gen} = '0;
    cmd = '0;
    pins = '0;
    taps = '0;
    n_mismatch = 0;
    n_compared = 0;
    void'($urandom(87));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({cols, hold, tone_n}, {16'h0000, 4'hF, 1'b1});
    // Latch loads over every nibble, decoded, blanked, paired and from table
    for (int i = 0; i < 16; i++) begin
      nib = 4'(i);
      x = 9'($urandom);
      op(OP_DEC_R, 9'h000, nib, 4'h0);
      lchk(SEG[nib]);
      op(OP_BLANK_R, 9'h000, nib, 4'h0);
      lchk(nib == 4'h0 ? 8'h00 : SEG[nib]);
      op(OP_DEC_HL, 9'h000, nib, 4'h0);
      lchk(SEG[nib]);
      op(OP_BLANK_HL, 9'h000, nib, 4'h0);
      lchk(nib == 4'h0 ? 8'h00 : SEG[nib]);
      op(OP_PAIR_R, 9'h000, nib, x[3:0]);
      lchk({x[3:0], nib});
      op(OP_PAIR_HL, 9'h000, nib, x[7:4]);
      lchk({x[7:4], nib});
      op(OP_TAB, x, 4'h0, 4'h0);
      lchk(x[7:0]);
    end
    op(io_op_e'(5'h1F), 9'h1FF, 4'hF, 4'hF);
    chk({lwe, awe, mwe}, 3'b000);
    // Port setup, write and read on all four ports
    for (int i = 0; i < 32; i++) begin
      p = i % 4;
      x = 9'($urandom);
      nib = 4'($urandom);
      op(io_op_e'(5'(8 + p)), x, 4'h0, 4'h0);
      chk(poe[p], x[3:0]);
      chk(pull[p], p == 2 ? (x[4] ? 4'(~x[3:0]) : 4'h0) : {4{x[4]}});
      if (p == 2) chk(hold, x[4] ? 4'h0 : 4'(~x[3:0]));
      op(io_op_e'(5'(12 + p)), 9'h000, nib, 4'h0);
      chk(pout[p], nib);
      pins[p] <= 4'($urandom);
      repeat (3) @(posedge clk);
      op(io_op_e'(5'(16 + p)), 9'h000, 4'h0, 4'h0);
      chk({awe, mwe, adata, mdata}, {2'b11, pins[p], pins[p]});
      chk(maddr, 9'h070 + 9'(cmd.work_reg_index));
    end
    // Special port A write with both immediate values, then the pin 4 pulse ends
    for (int d = 0; d < 2; d++) begin
      nib = 4'($urandom);
      op(OP_WRITE_A_SPECIAL, 9'(d), nib, 4'h0);
      chk(pout[0], {1'b1, 1'(d), nib[1:0]});
      @(posedge clk);
      #1;
      chk(pout[0][3], 1'b0);
    end
    // Every scan mode through all three setting forms, end nibbles first
    for (int i = 0; i < 48; i++) begin
      x = 9'($urandom);
      {x[7], x[5], x[4]} = 3'(i);
      if (i < 16) x[3:0] = {4{i[3]}};
      op(io_op_e'(5'(21 + i % 3)), x, x[3:0], x[7:4]);
      @(posedge clk);
      #1;
      chk(cols, scan_exp(x[7:0]));
    end
    // Wake on key press only, on every cycle, and refused when scanning is off
    wen <= 1'b1;
    op(OP_SCAN_IMM, 9'h000, 4'h0, 4'h0);
    scan_done(1'b0);
    key <= 1'b1;
    repeat (3) @(posedge clk);
    scan_done(1'b1);
    key <= 1'b0;
    op(OP_SCAN_IMM, 9'h040, 4'h0, 4'h0);
    scan_done(1'b1);
    op(OP_SCAN_IMM, 9'h060, 4'h0, 4'h0);
    scan_done(1'b0);
    // Buzzer carriers, plain first and then with envelopes
    for (int i = 0; i < 40; i++) begin
      x = 9'($urandom);
      x[8:6] = 3'(i);
      if (i < 8) x[5:0] = 6'h00;
      taps <= 16'($urandom);
      gen <= 1'($urandom);
      op(OP_BUZZ, x, 4'h0, 4'h0);
      @(posedge clk);
      #1;
      chk({tone, tone_n}, {tone_exp(x), ~tone_exp(x)});
    end
    // Converter oscillators, counter enable and gating
    for (int i = 0; i < 24; i++) begin
      x = 9'($urandom);
      op(OP_CONV, x, 4'h0, 4'h0);
      chk({osc, cen, t2g, cxg}, {x[2:0], |x[5:3], x[4] & ~x[5], x[5]});
    end
    report_and_stop();
  end
endmodule // io_instruction_peripheral_control_tb_top
`default_nettype wire
